//--- iopdc_top.sv
`timescale 1ns/10ps
// Behaviour
// [R1] usb pin drive-select bits 7,6 set drive
// [R2] usb pin pull-enable bit turns on pull
// [R3] usb mode ignores drive-select and pull-enable
// [R4] port-wide writes leave usb drive bits alone
// [R5] usb table: 0 low, 1 high/pull/float
// [R6] reset mode is high impedance analog
// [R7] analog mode gives no digital input
// [R8] high impedance digital: input on, driver off
// [R9] pull-up/down: strong one level, resistor other
// [R10] no pull modes on regulated special pins
// [R11] open drain: float one level, drive other
// [R12] strong mode drives the data level
// [R13] combined pull: always through the resistor
// [R14] port form: one bit per pin
// [R15] pin form: eight bits for one pin
// [R16] both forms alias the same state
// [R17] bidirectional: aux enable picks drive or input
// [R18] up to 16 aux enables, any routing
// [R19] edge rate only in strong and open drain
// [R20] one edge-rate bit per pin
// [R21] special pin pairs share one threshold
// [R22] hysteresis bit per special pin
// [R23] reset holds analog; nv settings load after
// [R24] low power keeps pin state
// [R25] mode codes distinct, zero is analog
// [R26] output data bit in both forms
module iopdc_top
  import iopdc_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_sys_rst,
  input wire logic i_por_rst,
  input wire logic i_wb_cyc,
  input wire logic i_wb_stb,
  input wire logic i_wb_we,
  input wire logic [IOPDC_ADR_W-1:0] i_wb_adr,
  input wire logic [IOPDC_DAT_W-1:0] i_wb_dat,
  input wire logic [3:0] i_wb_sel,
  output logic o_wb_ack,
  output logic [IOPDC_DAT_W-1:0] o_wb_dat,
  input wire logic [IOPDC_PINS-1:0] i_pad_in,
  input wire logic [IOPDC_USB_PINS-1:0] i_usb_pad_in,
  input wire logic [IOPDC_AUX_W-1:0] i_aux_oe,
  input wire logic i_sleep_hold,
  input wire logic [IOPDC_USB_PINS-1:0] i_usb_phy_value,
  input wire logic [IOPDC_USB_PINS-1:0] i_usb_phy_drive_n,
  output iopdc_pad_s [IOPDC_PINS-1:0] o_pad,
  output iopdc_pad_s [IOPDC_USB_PINS-1:0] o_usb_pad,
  output logic [IOPDC_PINS-1:0] o_pin_in,
  output logic [IOPDC_USB_PINS-1:0] o_usb_pin_in,
  output logic [IOPDC_PAIRS-1:0] o_thresh_from_global,
  output logic o_load_busy
);

  typedef enum {ST_LOAD, ST_RUN} iopdc_state_e;

  iopdc_state_e state;
  logic [IOPDC_IDX_W:0] ld_cnt;
  iopdc_mode_e nv_rd_data;
  iopdc_cfg_s [IOPDC_PINS-1:0] cfg;
  logic [IOPDC_PINS-1:0] regulated;
  logic [IOPDC_PAIRS-1:0] thresh_src;
  logic [IOPDC_DAT_W-1:0] oe_route;
  logic [IOPDC_USB_PINS-1:0] usb_pin_output_value;
  logic [IOPDC_USB_PINS-1:0] usb_pin_drive_select;
  logic [IOPDC_USB_PINS-1:0] usb_pin_pull_enable;
  logic usb_mode;
  logic [IOPDC_PINS-1:0] pad_meta;
  logic [IOPDC_PINS-1:0] pad_sync;
  logic [IOPDC_USB_PINS-1:0] usb_meta;
  logic [IOPDC_USB_PINS-1:0] usb_sync;
  logic bus_req;
  logic wr_fire;
  logic wr_lo;
  logic [IOPDC_BYTE-1:0] wbyte;
  logic pin_form;
  logic [IOPDC_IDX_W-1:0] pin_sel;
  logic nv_wr;
  logic ld_take;
  logic [IOPDC_IDX_W-1:0] ld_pin;
  logic [IOPDC_DAT_W-1:0] next_rdata;
  iopdc_pad_s [IOPDC_PINS-1:0] next_pad;
  iopdc_pad_s [IOPDC_USB_PINS-1:0] next_usb_pad;

  // mode decode shared by every general and special pin
  function automatic iopdc_pad_s drive_decode(input iopdc_mode_e m, input logic d,
                                              input logic slw, input logic hys,
                                              input logic reg_out);
    iopdc_pad_s p;
    p = PAD_RST;
    p.hyst = hys; // [R22]
    p.ibuf_en = (m != DM_HIZ_ANALOG); // [R6] [R8]
    case (m)
      DM_RES_PULL_UP: begin
        if (!d) begin
          p.drive_n = 1'b0;
        end else begin
          p.pull_up = !reg_out; // [R9] [R10]
        end
      end
      DM_RES_PULL_DOWN: begin
        if (d) begin
          p.drive_n = 1'b0;
          p.value = 1'b1;
        end else begin
          p.pull_dn = !reg_out; // [R9] [R10]
        end
      end
      DM_OD_LOW: begin
        p.drive_n = d; // [R11]
      end
      DM_OD_HIGH: begin
        p.drive_n = !d; // [R11]
        p.value = 1'b1;
      end
      DM_STRONG: begin
        p.drive_n = 1'b0; // [R12]
        p.value = d;
      end
      DM_RES_PULL_BOTH: begin
        p.pull_up = d && !reg_out; // [R13] [R10]
        p.pull_dn = !d && !reg_out;
      end
      default: begin
      end
    endcase
    // resistive modes have no edge-rate choice
    p.slow = slw && (m == DM_OD_LOW || m == DM_OD_HIGH || m == DM_STRONG); // [R19]
    return p;
  endfunction : drive_decode

  // merge one bus byte into a register under the writable mask
  function automatic logic [IOPDC_BYTE-1:0] byte_merge(input logic [IOPDC_BYTE-1:0] old,
                                                        input logic [IOPDC_BYTE-1:0] nb,
                                                        input logic [IOPDC_BYTE-1:0] msk);
    return (old & ~msk) | (nb & msk);
  endfunction : byte_merge

  iopdc_nv_store u_nv (
    .i_clk(i_clk),
    .i_por_rst(i_por_rst),
    .i_wr_en(nv_wr),
    .i_wr_addr(i_wb_dat[NV_IDX_LO +: IOPDC_IDX_W]),
    .i_wr_data(iopdc_mode_e'(i_wb_dat[IOPDC_IDX_W-1:0])),
    .i_rd_addr(ld_cnt[IOPDC_IDX_W-1:0]),
    .o_rd_data(nv_rd_data)
  );

  // bus requests wait until the reset settings are loaded
  assign bus_req = i_wb_cyc && i_wb_stb && (state == ST_RUN);
  assign wr_fire = bus_req && i_wb_we && o_wb_ack;
  assign wr_lo = wr_fire && i_wb_sel[0];
  assign wbyte = i_wb_dat[IOPDC_BYTE-1:0];
  assign pin_form = (i_wb_adr >= REG_PIN_BASE) && (i_wb_adr <= REG_PIN_LAST);
  assign pin_sel = i_wb_adr[2 +: IOPDC_IDX_W];
  assign nv_wr = wr_lo && i_wb_sel[1] && (i_wb_adr == REG_NV_PROG);
  assign ld_take = (state == ST_LOAD) && (ld_cnt != '0);
  assign ld_pin = IOPDC_IDX_W'(ld_cnt - 1'b1);
  assign o_load_busy = (state == ST_LOAD);
  assign o_thresh_from_global = thresh_src; // [R21]

  // nv read data lags its address by one cycle, hence the count to eight
  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      state <= ST_LOAD; // [R23]
      ld_cnt <= '0;
    end else begin
      case (state)
        ST_LOAD: begin
          if (ld_cnt == (IOPDC_IDX_W+1)'(IOPDC_PINS)) begin
            state <= ST_RUN;
          end
          ld_cnt <= ld_cnt + 1'b1;
        end
        default: begin
          ld_cnt <= '0;
        end
      endcase
    end
  end

  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      pad_meta <= '0;
      pad_sync <= '0;
      usb_meta <= '0;
      usb_sync <= '0;
    end else begin
      pad_meta <= i_pad_in;
      pad_sync <= pad_meta;
      usb_meta <= i_usb_pad_in;
      usb_sync <= usb_meta;
    end
  end

  // one store, two views: port writes touch a bit of every pin, pin writes one pin
  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      cfg <= {IOPDC_PINS{CFG_RST}}; // [R6] [R25]
    end else begin
      for (int i = 0; i < IOPDC_PINS; i++) begin
        if (ld_take && ld_pin == IOPDC_IDX_W'(i)) begin
          cfg[i].mode <= nv_rd_data; // [R23]
        end else if (wr_lo) begin
          if (pin_form && pin_sel == IOPDC_IDX_W'(i)) begin // [R15] [R16]
            cfg[i].data <= wbyte[PF_DATA]; // [R26]
            cfg[i].mode <= iopdc_mode_e'(wbyte[PF_MODE_LO +: IOPDC_IDX_W]);
            cfg[i].slow <= wbyte[PF_SLOW];
            cfg[i].bidir <= wbyte[PF_BIDIR];
            cfg[i].hyst <= wbyte[PF_HYST] && IOPDC_SPECIAL_MASK[i];
          end else if (i_wb_adr == REG_OUT_DATA) begin // [R14] [R26]
            cfg[i].data <= wbyte[i];
          end else if (i_wb_adr == REG_MODE_B0) begin
            cfg[i].mode[0] <= wbyte[i];
          end else if (i_wb_adr == REG_MODE_B1) begin
            cfg[i].mode[1] <= wbyte[i];
          end else if (i_wb_adr == REG_MODE_B2) begin
            cfg[i].mode[2] <= wbyte[i];
          end else if (i_wb_adr == REG_EDGE_SLOW) begin
            cfg[i].slow <= wbyte[i]; // [R20]
          end else if (i_wb_adr == REG_BIDIR_EN) begin
            cfg[i].bidir <= wbyte[i];
          end else if (i_wb_adr == REG_HYST_EN) begin
            cfg[i].hyst <= wbyte[i] && IOPDC_SPECIAL_MASK[i]; // [R22]
          end
        end
      end
    end
  end

  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      regulated <= '0;
      thresh_src <= '0;
    end else if (wr_lo && i_wb_adr == REG_REGULATED) begin
      regulated <= byte_merge(regulated, wbyte, IOPDC_SPECIAL_MASK);
    end else if (wr_lo && i_wb_adr == REG_THRESH_SRC) begin
      thresh_src <= wbyte[IOPDC_PAIRS-1:0]; // [R21]
    end
  end

  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      oe_route <= '0;
    end else if (wr_fire && i_wb_adr == REG_OE_ROUTE) begin
      for (int b = 0; b < 4; b++) begin
        if (i_wb_sel[b]) begin
          oe_route[b*IOPDC_BYTE +: IOPDC_BYTE] <= i_wb_dat[b*IOPDC_BYTE +: IOPDC_BYTE]; // [R18]
        end
      end
    end
  end

  // usb pins live only in their own registers, out of reach of port-wide writes
  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      usb_pin_output_value <= '0;
      usb_pin_drive_select <= '0;
      usb_pin_pull_enable <= '0;
      usb_mode <= 1'b0;
    end else if (wr_lo) begin
      if (i_wb_adr == REG_USB_OUT) begin
        usb_pin_output_value <= wbyte[IOPDC_USB_LO +: IOPDC_USB_PINS];
      end else if (i_wb_adr == REG_USB_DRIVE) begin
        usb_pin_drive_select <= wbyte[IOPDC_USB_LO +: IOPDC_USB_PINS]; // [R1] [R4]
      end else if (i_wb_adr == REG_USB_PULL) begin
        usb_pin_pull_enable <= wbyte[IOPDC_USB_LO +: IOPDC_USB_PINS]; // [R2] [R4]
      end else if (i_wb_adr == REG_USB_MODE) begin
        usb_mode <= wbyte[0];
      end
    end
  end

  always_comb begin
    for (int i = 0; i < IOPDC_PINS; i++) begin
      iopdc_mode_e eff;
      logic oe;
      eff = cfg[i].mode;
      oe = i_aux_oe[oe_route[i*IOPDC_SEL_W +: IOPDC_SEL_W]]; // [R18]
      if (cfg[i].bidir && !oe) begin
        eff = DM_HIZ_DIGITAL; // [R17]
      end
      next_pad[i] = drive_decode(eff, cfg[i].data, cfg[i].slow, cfg[i].hyst, regulated[i]);
    end
  end

  always_comb begin
    for (int u = 0; u < IOPDC_USB_PINS; u++) begin
      next_usb_pad[u] = PAD_RST;
      next_usb_pad[u].ibuf_en = 1'b1;
      if (usb_mode) begin
        next_usb_pad[u].drive_n = i_usb_phy_drive_n[u]; // [R3]
        next_usb_pad[u].value = i_usb_phy_value[u];
      end else if (!usb_pin_output_value[u]) begin
        next_usb_pad[u].drive_n = 1'b0; // [R5]
      end else if (usb_pin_drive_select[u]) begin
        next_usb_pad[u].drive_n = 1'b0; // [R1] [R5]
        next_usb_pad[u].value = 1'b1;
      end else begin
        next_usb_pad[u].pull_up = usb_pin_pull_enable[u]; // [R2] [R5]
      end
    end
  end

  // frozen while asleep so the pins keep their last state
  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      o_pad <= {IOPDC_PINS{PAD_RST}}; // [R23]
      o_usb_pad <= {IOPDC_USB_PINS{PAD_RST}};
    end else if (!i_sleep_hold) begin // [R24]
      o_pad <= next_pad;
      o_usb_pad <= next_usb_pad;
    end
  end

  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      o_pin_in <= '0;
      o_usb_pin_in <= '0;
    end else begin
      for (int i = 0; i < IOPDC_PINS; i++) begin
        o_pin_in[i] <= pad_sync[i] && o_pad[i].ibuf_en; // [R7]
      end
      o_usb_pin_in <= usb_sync;
    end
  end

  always_comb begin
    next_rdata = '0;
    if (pin_form) begin
      next_rdata[PF_DATA] = cfg[pin_sel].data;
      next_rdata[PF_STATE] = o_pin_in[pin_sel];
      next_rdata[PF_MODE_LO +: IOPDC_IDX_W] = cfg[pin_sel].mode;
      next_rdata[PF_SLOW] = cfg[pin_sel].slow;
      next_rdata[PF_BIDIR] = cfg[pin_sel].bidir;
      next_rdata[PF_HYST] = cfg[pin_sel].hyst;
    end else if (i_wb_adr == REG_PIN_STATE) begin
      next_rdata[IOPDC_PINS-1:0] = o_pin_in;
    end else if (i_wb_adr == REG_OE_ROUTE) begin
      next_rdata = oe_route;
    end else if (i_wb_adr == REG_REGULATED) begin
      next_rdata[IOPDC_PINS-1:0] = regulated;
    end else if (i_wb_adr == REG_THRESH_SRC) begin
      next_rdata[IOPDC_PAIRS-1:0] = thresh_src;
    end else if (i_wb_adr == REG_USB_OUT) begin
      next_rdata[IOPDC_USB_LO +: IOPDC_USB_PINS] = usb_pin_output_value;
    end else if (i_wb_adr == REG_USB_DRIVE) begin
      next_rdata[IOPDC_USB_LO +: IOPDC_USB_PINS] = usb_pin_drive_select;
    end else if (i_wb_adr == REG_USB_PULL) begin
      next_rdata[IOPDC_USB_LO +: IOPDC_USB_PINS] = usb_pin_pull_enable;
    end else if (i_wb_adr == REG_USB_MODE) begin
      next_rdata[0] = usb_mode;
    end else if (i_wb_adr == REG_USB_STATE) begin
      next_rdata[IOPDC_USB_LO +: IOPDC_USB_PINS] = o_usb_pin_in;
    end else begin
      for (int i = 0; i < IOPDC_PINS; i++) begin
        if (i_wb_adr == REG_OUT_DATA) begin
          next_rdata[i] = cfg[i].data;
        end else if (i_wb_adr == REG_MODE_B0) begin
          next_rdata[i] = cfg[i].mode[0];
        end else if (i_wb_adr == REG_MODE_B1) begin
          next_rdata[i] = cfg[i].mode[1];
        end else if (i_wb_adr == REG_MODE_B2) begin
          next_rdata[i] = cfg[i].mode[2];
        end else if (i_wb_adr == REG_EDGE_SLOW) begin
          next_rdata[i] = cfg[i].slow;
        end else if (i_wb_adr == REG_BIDIR_EN) begin
          next_rdata[i] = cfg[i].bidir;
        end else if (i_wb_adr == REG_HYST_EN) begin
          next_rdata[i] = cfg[i].hyst;
        end
      end
    end
  end

  // unmapped words ack with zero data
  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      o_wb_ack <= 1'b0;
      o_wb_dat <= '0;
    end else begin
      o_wb_ack <= bus_req && !o_wb_ack;
      if (bus_req && !o_wb_ack && !i_wb_we) begin
        o_wb_dat <= next_rdata;
      end
    end
  end

endmodule : iopdc_top

//--- iopdc_pkg.sv
package iopdc_pkg;

  localparam int IOPDC_PINS = 8;
  localparam int IOPDC_USB_PINS = 2;
  localparam int IOPDC_AUX_W = 16;
  localparam int IOPDC_SEL_W = 4;
  localparam int IOPDC_IDX_W = 3;
  localparam int IOPDC_ADR_W = 8;
  localparam int IOPDC_DAT_W = 32;
  localparam int IOPDC_BYTE = 8;

  // special pins sit in the upper half; pins pair up on one threshold
  localparam logic [IOPDC_PINS-1:0] IOPDC_SPECIAL_MASK = 8'hF0;
  localparam int IOPDC_SPECIAL_BASE = 4;
  localparam int IOPDC_PAIRS = 2;

  // usb-capable pins sit at bit positions 7 and 6 of their own port
  localparam int IOPDC_USB_LO = 6;

  // byte offsets of the register words
  localparam logic [IOPDC_ADR_W-1:0] REG_OUT_DATA = 8'h00;
  localparam logic [IOPDC_ADR_W-1:0] REG_PIN_STATE = 8'h04;
  localparam logic [IOPDC_ADR_W-1:0] REG_MODE_B0 = 8'h08;
  localparam logic [IOPDC_ADR_W-1:0] REG_MODE_B1 = 8'h0C;
  localparam logic [IOPDC_ADR_W-1:0] REG_MODE_B2 = 8'h10;
  localparam logic [IOPDC_ADR_W-1:0] REG_EDGE_SLOW = 8'h14;
  localparam logic [IOPDC_ADR_W-1:0] REG_BIDIR_EN = 8'h18;
  localparam logic [IOPDC_ADR_W-1:0] REG_HYST_EN = 8'h1C;
  localparam logic [IOPDC_ADR_W-1:0] REG_REGULATED = 8'h20;
  localparam logic [IOPDC_ADR_W-1:0] REG_THRESH_SRC = 8'h24;
  localparam logic [IOPDC_ADR_W-1:0] REG_OE_ROUTE = 8'h28;
  localparam logic [IOPDC_ADR_W-1:0] REG_NV_PROG = 8'h2C;
  localparam logic [IOPDC_ADR_W-1:0] REG_USB_OUT = 8'h30;
  localparam logic [IOPDC_ADR_W-1:0] REG_USB_DRIVE = 8'h34;
  localparam logic [IOPDC_ADR_W-1:0] REG_USB_PULL = 8'h38;
  localparam logic [IOPDC_ADR_W-1:0] REG_USB_MODE = 8'h3C;
  localparam logic [IOPDC_ADR_W-1:0] REG_USB_STATE = 8'h40;
  localparam logic [IOPDC_ADR_W-1:0] REG_PIN_BASE = 8'h80;
  localparam logic [IOPDC_ADR_W-1:0] REG_PIN_LAST = 8'h9C;

  // pin-form field positions
  localparam int PF_DATA = 0;
  localparam int PF_STATE = 1;
  localparam int PF_MODE_LO = 2;
  localparam int PF_SLOW = 5;
  localparam int PF_BIDIR = 6;
  localparam int PF_HYST = 7;

  // nv programming word: mode in low bits, pin index above
  localparam int NV_IDX_LO = 8;

  typedef enum logic [2:0] {
    DM_HIZ_ANALOG = 3'h0,
    DM_HIZ_DIGITAL = 3'h1,
    DM_RES_PULL_UP = 3'h2,
    DM_RES_PULL_DOWN = 3'h3,
    DM_OD_LOW = 3'h4,
    DM_OD_HIGH = 3'h5,
    DM_STRONG = 3'h6,
    DM_RES_PULL_BOTH = 3'h7
  } iopdc_mode_e;

  localparam iopdc_mode_e NV_RST_MODE = DM_HIZ_ANALOG;

  typedef struct packed {
    logic data;
    iopdc_mode_e mode;
    logic slow;
    logic bidir;
    logic hyst;
  } iopdc_cfg_s;

  localparam iopdc_cfg_s CFG_RST = '{data: 1'b0, mode: DM_HIZ_ANALOG, slow: 1'b0,
                                     bidir: 1'b0, hyst: 1'b0};

  // drive_n low while the pad driver is on
  typedef struct packed {
    logic drive_n;
    logic value;
    logic pull_up;
    logic pull_dn;
    logic ibuf_en;
    logic slow;
    logic hyst;
  } iopdc_pad_s;

  localparam iopdc_pad_s PAD_RST = '{drive_n: 1'b1, value: 1'b0, pull_up: 1'b0,
                                     pull_dn: 1'b0, ibuf_en: 1'b0, slow: 1'b0, hyst: 1'b0};

endpackage : iopdc_pkg

//--- iopdc_nv_store.sv
`timescale 1ns/10ps
// survives system reset; only power-on reset restores the defaults
module iopdc_nv_store
  import iopdc_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_por_rst,
  input wire logic i_wr_en,
  input wire logic [IOPDC_IDX_W-1:0] i_wr_addr,
  input wire iopdc_mode_e i_wr_data,
  input wire logic [IOPDC_IDX_W-1:0] i_rd_addr,
  output iopdc_mode_e o_rd_data
);

  iopdc_mode_e mem [IOPDC_PINS];

  always_ff @(posedge i_clk or posedge i_por_rst) begin
    if (i_por_rst) begin
      for (int k = 0; k < IOPDC_PINS; k++) begin
        mem[k] <= NV_RST_MODE;
      end
    end else if (i_wr_en) begin
      mem[i_wr_addr] <= i_wr_data;
    end
  end

  always_ff @(posedge i_clk or posedge i_por_rst) begin
    if (i_por_rst) begin
      o_rd_data <= NV_RST_MODE;
    end else begin
      o_rd_data <= mem[i_rd_addr];
    end
  end

endmodule : iopdc_nv_store

//--- iopdc_pad_env.sv
`timescale 1ns/10ps
// far-side circuit; a released pad with no pull and no external drive reads a toggling level
module iopdc_pad_env
  import iopdc_pkg::*;
#(
  parameter int N = 8
)
(
  input wire logic i_clk,
  input wire iopdc_pad_s [N-1:0] i_pad,
  input wire logic [N-1:0] i_ext_en,
  input wire logic [N-1:0] i_ext_val,
  output logic [N-1:0] o_level
);
  logic tog = 1'b0;
  always @(posedge i_clk) tog <= !tog;
  always_comb begin
    for (int i = 0; i < N; i++) begin
      if (!i_pad[i].drive_n) o_level[i] = i_pad[i].value;
      else if (i_ext_en[i]) o_level[i] = i_ext_val[i];
      else if (i_pad[i].pull_up | i_pad[i].pull_dn) o_level[i] = i_pad[i].pull_up;
      else o_level[i] = tog ^ 1'(i % 2);
    end
  end
endmodule : iopdc_pad_env

//--- iopdc_top_checker.sv
`timescale 1ns/10ps
module iopdc_top_checker
  import iopdc_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_sys_rst,
  input wire logic i_wb_cyc,
  input wire logic i_wb_stb,
  input wire logic i_wb_we,
  input wire logic [IOPDC_ADR_W-1:0] i_wb_adr,
  input wire logic [IOPDC_DAT_W-1:0] i_wb_dat,
  input wire logic [3:0] i_wb_sel,
  input wire logic o_wb_ack,
  input wire logic i_sleep_hold,
  input wire logic [IOPDC_USB_PINS-1:0] i_usb_phy_drive_n,
  input wire iopdc_pad_s [IOPDC_PINS-1:0] o_pad,
  input wire iopdc_pad_s [IOPDC_USB_PINS-1:0] o_usb_pad,
  input wire logic [IOPDC_PINS-1:0] o_pin_in,
  input wire logic o_load_busy
);
  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (i_sys_rst);
  logic usb_mode;
  logic [3:0] edges;
  logic [IOPDC_PINS-1:0] ibuf;
  logic [IOPDC_PINS-1:0] both;
  logic [IOPDC_PINS-1:0] drvp;
  always_comb begin
    for (int i = 0; i < IOPDC_PINS; i++) begin
      ibuf[i] = o_pad[i].ibuf_en;
      both[i] = o_pad[i].pull_up & o_pad[i].pull_dn;
      drvp[i] = !o_pad[i].drive_n & (o_pad[i].pull_up | o_pad[i].pull_dn);
    end
  end
  // saturates so a long run never wraps back into the load window
  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) edges <= 4'h0;
    else if (edges != 4'hF) edges <= edges + 4'h1;
  end
  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) usb_mode <= 1'b0;
    else if (i_wb_cyc && i_wb_stb && i_wb_we && o_wb_ack && i_wb_sel[0] &&
             i_wb_adr == REG_USB_MODE) usb_mode <= i_wb_dat[0];
  end
  chk_load_span: assert property (o_load_busy == (edges < 4'h9))
    else $error("load busy span wrong");
  chk_load_quiet: assert property (o_load_busy |-> (!o_wb_ack) [*2])
    else $error("bus answered during load");
  chk_analog_no_in: assert property ((o_pin_in & ~ibuf & ~$past(ibuf)) == 8'h00)
    else $error("input seen with buffer off");
  chk_pull_excl: assert property (both == 8'h00)
    else $error("both pulls on");
  chk_drive_no_pull: assert property (drvp == 8'h00)
    else $error("pull on a driven pad");
  chk_usb_phy: assert property ($past(usb_mode) && !$past(i_sleep_hold) |->
    o_usb_pad[0].drive_n == $past(i_usb_phy_drive_n[0]) &&
    o_usb_pad[1].drive_n == $past(i_usb_phy_drive_n[1]))
    else $error("usb pad not following phy");
  chk_sleep_hold: assert property ($past(i_sleep_hold) |-> $stable(o_pad) &&
    $stable(o_usb_pad))
    else $error("pads moved while held");
  chk_ack_pulse: assert property (o_wb_ack |=> !o_wb_ack)
    else $error("ack longer than one cycle");
  cov_write: cover property (i_wb_we && o_wb_ack);
  cov_usb: cover property (usb_mode && !o_usb_pad[0].drive_n);
  cov_sleep: cover property ($fell(i_sleep_hold));
endmodule : iopdc_top_checker

bind iopdc_top iopdc_top_checker u_chk (.i_clk(i_clk), .i_sys_rst(i_sys_rst),
  .i_wb_cyc(i_wb_cyc), .i_wb_stb(i_wb_stb), .i_wb_we(i_wb_we), .i_wb_adr(i_wb_adr),
  .i_wb_dat(i_wb_dat), .i_wb_sel(i_wb_sel), .o_wb_ack(o_wb_ack),
  .i_sleep_hold(i_sleep_hold), .i_usb_phy_drive_n(i_usb_phy_drive_n), .o_pad(o_pad),
  .o_usb_pad(o_usb_pad), .o_pin_in(o_pin_in), .o_load_busy(o_load_busy));

//--- test_io_pin_drive_config.sv
`timescale 1ns/10ps
module test_io_pin_drive_config;
  import iopdc_pkg::*;
  typedef struct packed {logic [31:0] e; logic [31:0] m;} iopdc_exp_s;
  logic i_clk, i_sys_rst, i_por_rst, cyc, stb, we, sleep, ack, busy;
  logic [7:0] adr, pad_in, pin_in, ext_en, ext_val, r0, r1;
  logic [31:0] wdat, rdat;
  logic [3:0] sel;
  logic [15:0] aux;
  logic [1:0] usb_in, phy_v, phy_d, thr;
  logic [6:0] mu;
  iopdc_pad_s [7:0] pad;
  iopdc_pad_s [1:0] upad;
  iopdc_pad_s e;
  iopdc_exp_s q[$];
  iopdc_exp_s cur;
  int n_fail = 0;
  int checked = 0;
  int p, k;
  iopdc_top u_dut (.i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_por_rst(i_por_rst),
    .i_wb_cyc(cyc), .i_wb_stb(stb), .i_wb_we(we), .i_wb_adr(adr), .i_wb_dat(wdat),
    .i_wb_sel(sel), .o_wb_ack(ack), .o_wb_dat(rdat), .i_pad_in(pad_in),
    .i_usb_pad_in(usb_in), .i_aux_oe(aux), .i_sleep_hold(sleep), .i_usb_phy_value(phy_v),
    .i_usb_phy_drive_n(phy_d), .o_pad(pad), .o_usb_pad(upad), .o_pin_in(pin_in),
    .o_usb_pin_in(), .o_thresh_from_global(thr), .o_load_busy(busy));
  iopdc_pad_env #(.N(8)) u_env (.i_clk(i_clk), .i_pad(pad), .i_ext_en(ext_en),
    .i_ext_val(ext_val), .o_level(pad_in));
  iopdc_pad_env #(.N(2)) u_uenv (.i_clk(i_clk), .i_pad(upad), .i_ext_en(2'h0),
    .i_ext_val(2'h0), .o_level(usb_in));
  initial begin
    i_clk = 1'b0;
    forever #5 i_clk = ~i_clk;
  end
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp, input string what);
    checked++;
    if (got !== exp) begin
      n_fail++;
      $display("[FAIL] %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask : cmp
  task automatic cmp_pad(input iopdc_pad_s got, input iopdc_pad_s exp, input logic [6:0] m);
    cmp({25'h0, got & m}, {25'h0, exp & m}, "pad");
  endtask : cmp_pad
  // reads are judged by the monitor at the ack edge
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d,
                    input logic [31:0] m = 32'hFFFF_FFFF);
    int n = 0;
    @(posedge i_clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    sel <= 4'hF;
    adr <= a;
    wdat <= d;
    if (!w) q.push_back('{e: d, m: m});
    do begin
      @(posedge i_clk);
      n++;
    end while (!ack && n < 40);
    cmp({31'h0, ack}, 32'h1, "no ack");
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask : wb
  task automatic chk_pad(input int pn, input logic [2:0] md, input logic d, input logic s);
    iopdc_pad_s x;
    x = PAD_RST;
    x.drive_n = !(md == 3'h6 || md == {2'b01, d} || md == {2'b10, d});
    x.value = d;
    x.pull_up = d && (md == 3'h2 || md == 3'h7);
    x.pull_dn = !d && (md == 3'h3 || md == 3'h7);
    x.ibuf_en = md != 3'h0;
    x.slow = s && md inside {3'h4, 3'h5, 3'h6};
    repeat (2) @(posedge i_clk);
    // strong mode leaves the input buffer open
    cmp_pad(pad[pn], x, {1'b1, !x.drive_n, 2'h3, md != 3'h6, 2'h3});
  endtask : chk_pad
  task automatic do_reset(input logic por);
    @(posedge i_clk);
    i_sys_rst <= 1'b1;
    i_por_rst <= por;
    repeat (20) @(posedge i_clk);
    for (int i = 0; i < 8; i++) cmp_pad(pad[i], PAD_RST, 7'h7F);
    i_sys_rst <= 1'b0;
    i_por_rst <= 1'b0;
    repeat (12) @(posedge i_clk);
  endtask : do_reset
  task automatic results();
    $display("checked %0d n_fail %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : results
  always @(posedge i_clk) begin
    if (cyc && !we && ack && q.size() > 0) begin
      cur = q.pop_front();
      cmp(rdat & cur.m, cur.e & cur.m, "read");
    end
  end
  initial begin
    #100000;
    n_fail++;
    $display("[FAIL] %0t watchdog expired", $time);
    results();
  end
  initial begin
    {i_sys_rst, i_por_rst, cyc, stb, we, sleep} = 6'h30;
    {adr, wdat, sel, aux, ext_en, ext_val, phy_v, phy_d} = 80'hF;
    p = $urandom(32'hF82C5023);
    do_reset(1'b1);
    for (k = 0; k < 3; k++) wb(1'b0, REG_MODE_B0 + 8'(4 * k), 32'h0);
    r0 = 8'($urandom);
    r1 = 8'($urandom);
    wb(1'b1, REG_MODE_B1, {24'h0, r0});
    wb(1'b1, REG_OUT_DATA, {24'h0, r1});
    for (k = 0; k < 8; k++) wb(1'b0, REG_PIN_BASE + 8'(4 * k), {28'h0, r0[k], 2'h0, r1[k]}, 32'h9);
    for (k = 0; k < 16; k++) begin
      p = $urandom_range(3);
      wb(1'b1, REG_PIN_BASE + 8'(4 * p), {26'h0, 1'b1, 3'(k >> 1), 1'b0, 1'(k)});
      wb(1'b0, REG_MODE_B2, {24'h0, 8'(k >> 3) << p}, 32'h1 << p);
      chk_pad(p, 3'(k >> 1), 1'(k), 1'b1);
    end
    wb(1'b1, REG_EDGE_SLOW, 32'h5A);
    wb(1'b0, REG_PIN_BASE + 8'h04, 32'h20, 32'h20);
    k = $urandom_range(15);
    wb(1'b1, REG_OE_ROUTE, 32'(k) << 4);
    wb(1'b1, REG_PIN_BASE + 8'h04, 32'h59);
    aux <= ~(16'h1 << k);
    chk_pad(1, 3'h1, 1'b1, 1'b0);
    aux <= 16'h1 << k;
    chk_pad(1, 3'h6, 1'b1, 1'b0);
    for (k = 0; k < 8; k++) begin
      wb(1'b1, REG_USB_OUT, k[0] ? 32'hC0 : 32'h0);
      wb(1'b1, REG_USB_DRIVE, k[1] ? 32'hC0 : 32'h0);
      wb(1'b1, REG_USB_PULL, k[2] ? 32'hC0 : 32'h0);
      e = '{k[0] & !k[1], k[0], k[0] & !k[1] & k[2], 1'b0, 1'b1, 1'b0, 1'b0};
      mu = {1'b1, k[1] | !k[0], 5'h1F};
      repeat (2) @(posedge i_clk);
      cmp_pad(upad[0], e, mu);
      cmp_pad(upad[1], e, mu);
    end
    wb(1'b1, REG_MODE_B0, 32'h0);
    wb(1'b1, REG_OUT_DATA, 32'h0);
    repeat (2) @(posedge i_clk);
    cmp_pad(upad[1], e, mu);
    wb(1'b0, REG_USB_STATE, 32'hC0);
    wb(1'b1, REG_USB_MODE, 32'h1);
    for (k = 0; k < 4; k++) begin
      phy_v <= 2'($urandom);
      phy_d <= 2'($urandom);
      repeat (2) @(posedge i_clk);
      cmp({31'h0, upad[0].drive_n}, {31'h0, phy_d[0]}, "usb phy");
    end
    wb(1'b1, REG_USB_MODE, 32'h0);
    e = pad[1];
    sleep <= 1'b1;
    wb(1'b1, REG_PIN_BASE + 8'h04, 32'h18);
    repeat (2) @(posedge i_clk);
    cmp_pad(pad[1], e, 7'h7F);
    sleep <= 1'b0;
    chk_pad(1, 3'h6, 1'b0, 1'b0);
    ext_en <= 8'h04;
    ext_val <= 8'h04;
    wb(1'b1, REG_PIN_BASE + 8'h08, 32'h0);
    repeat (5) @(posedge i_clk);
    cmp({31'h0, pin_in[2]}, 32'h0, "analog input");
    wb(1'b1, REG_PIN_BASE + 8'h08, 32'h4);
    repeat (5) @(posedge i_clk);
    wb(1'b0, REG_PIN_STATE, 32'h4, 32'h4);
    wb(1'b1, REG_REGULATED, 32'h20);
    wb(1'b1, REG_PIN_BASE + 8'h14, 32'h9);
    repeat (2) @(posedge i_clk);
    cmp({31'h0, pad[5].pull_up}, 32'h0, "regulated pull");
    wb(1'b1, REG_HYST_EN, 32'hFF);
    wb(1'b0, REG_HYST_EN, 32'hF0, 32'hFF);
    wb(1'b1, REG_THRESH_SRC, 32'h2);
    wb(1'b0, 8'h60, 32'h0);
    cmp({30'h0, thr}, 32'h2, "threshold");
    wb(1'b1, REG_NV_PROG, 32'h202);
    wb(1'b0, REG_NV_PROG, 32'h0);
    do_reset(1'b0);
    wb(1'b0, REG_PIN_BASE + 8'h08, 32'h8, 32'h1C);
    chk_pad(2, 3'h2, 1'b0, 1'b0);
    results();
  end
endmodule : test_io_pin_drive_config
